// ==== hw/xor_accumulator_with_file_defines.svh ====
// Constants for the exclusive-OR accumulator-with-file execute block
`ifndef XAF_DEFINES_SVH
`define XAF_DEFINES_SVH
`define XAF_OPC_HI 15
`define XAF_OPC_LO 10
`define XAF_OPC_VAL 6'h06
`define XAF_D_BIT 9
`define XAF_A_BIT 8
`define XAF_ILO_MAX 8'h5f
`define XAF_ACC_HI 4'hf
`define XAF_ACC_SPLIT 8'h60
`define XAF_ACC_RST 8'h00
`define XAF_ADDR_RST 12'h000
`define XAF_ACC_LO 4'h0
`define XAF_F_HI 7
`define XAF_F_LO 0
`define XAF_SIGN_BIT 7
`define XAF_ZERO_BYTE 8'h00
`define XAF_DATA_RST 8'h00
`endif

// ==== hw/xaf_pkg.sv ====
// Types shared by the exclusive-OR accumulator-with-file execute block
package xaf_pkg;
    typedef enum logic [2:0] {
        XAF_IDLE = 3'b001,
        XAF_READ = 3'b010,
        XAF_WRITE = 3'b100
    } xaf_state_t;
endpackage : xaf_pkg

// ==== hw/xaf_exec.sv ====
// Execute unit for the exclusive-OR accumulator-with-file instruction
// How it works
// - Opcode 0001 10da ffff ffff reads the file register, XORs it with the accumulator and updates N and Z.
// - With d clear the result goes to the accumulator and the file register is not written.
// - With d set the result is written back to the addressed file register, not the accumulator.
// - With a clear and the extension off the address resolves in the access bank.
// - With a set the bank select pointer picks the bank above the eight-bit file address.
// - With a clear, the extension on and f at most 5Fh, indexed literal offset mode is used.
// - In that mode f is an offset added to the second indirect pointer.
`timescale 1ns/1ns
`include "xor_accumulator_with_file_defines.svh"
module xaf_exec #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic ext_enable,
    input wire logic [3:0] bank_select_pointer,
    input wire logic [ADDR_W-1:0] indirect_pointer_two,
    input wire logic [7:0] mem_rdata,
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic [7:0] acc,
    output logic flag_n,
    output logic flag_z,
    output logic done,
    output logic busy
);
    // Sequencer state and the destination latched at start
    xaf_pkg::xaf_state_t state_q, state_d;
    logic dest_q;
    logic [7:0] result;

    // ---------------------------------------------
    // Decode and address resolution
    // ---------------------------------------------
    // Opcode match and the two mode bits
    wire logic is_xor = instr_word[`XAF_OPC_HI:`XAF_OPC_LO] == `XAF_OPC_VAL;
    wire logic bit_d = instr_word[`XAF_D_BIT];
    wire logic bit_a = instr_word[`XAF_A_BIT];
    wire logic [7:0] f_field = instr_word[`XAF_F_HI:`XAF_F_LO];

    // Extension steals only the low part of the access bank; a set never indexes
    wire logic indexed = !bit_a && ext_enable && (f_field <= `XAF_ILO_MAX);
    // Offset wraps at the address width, as a pointer add would
    wire logic [ADDR_W-1:0] addr_ilo = indirect_pointer_two + ADDR_W'(f_field);

    // Bank select pointer forms the upper address bits
    wire logic [ADDR_W-1:0] addr_bank = ADDR_W'({bank_select_pointer, f_field});

    // Access bank below 60h is bank 0, 60h and above maps to special registers
    wire logic [3:0] acc_bank = (f_field < `XAF_ACC_SPLIT) ? `XAF_ACC_LO : `XAF_ACC_HI;
    wire logic [ADDR_W-1:0] addr_access = ADDR_W'({acc_bank, f_field});

    // Indexed mode takes priority over the plain access bank
    wire logic [ADDR_W-1:0] eff_addr = indexed ? addr_ilo : (bit_a ? addr_bank : addr_access);

    // Requests while busy are dropped, not queued
    wire logic start = instr_valid && is_xor && (state_q == xaf_pkg::XAF_IDLE);

    // ---------------------------------------------
    // Arithmetic and status
    // ---------------------------------------------
    // Memory read is combinational, so the result is valid while the read stands
    assign result = acc ^ mem_rdata;
    wire logic res_zero = (result == `XAF_ZERO_BYTE);
    wire logic res_neg = result[`XAF_SIGN_BIT];

    // ---------------------------------------------
    // Sequencer: read, then write destination
    // ---------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            xaf_pkg::XAF_IDLE: if (start) state_d = xaf_pkg::XAF_READ;
            xaf_pkg::XAF_READ: state_d = xaf_pkg::XAF_WRITE;
            xaf_pkg::XAF_WRITE: state_d = xaf_pkg::XAF_IDLE;
            default: state_d = xaf_pkg::XAF_IDLE;
        endcase
    end

    // State, address latch and read strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= xaf_pkg::XAF_IDLE;
            mem_addr <= ADDR_W'(`XAF_ADDR_RST);
            mem_rd <= 1'b0;
            dest_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mem_rd <= start;
            if (start) begin
                mem_addr <= eff_addr;
                dest_q <= bit_d;
            end
        end
    end

    // Result to destination and flags; file data is used at the end of the read-strobe cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acc <= `XAF_ACC_RST;
            flag_n <= 1'b0;
            flag_z <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= `XAF_DATA_RST;
            done <= 1'b0;
        end else begin
            mem_wr <= 1'b0;
            done <= 1'b0;
            if (state_q == xaf_pkg::XAF_READ) begin
                flag_z <= res_zero;
                flag_n <= res_neg;
                done <= 1'b1;
                if (dest_q) begin
                    mem_wr <= 1'b1;
                    mem_wdata <= result;
                end else begin
                    acc <= result;
                end
            end
        end
    end
    // Busy mirrors the sequencer from a flop
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) busy <= 1'b0;
        else busy <= (state_d != xaf_pkg::XAF_IDLE);
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    // Read strobe one cycle after start, done the cycle after
    property p_read_after_start;
        @(posedge mclk) disable iff (!reset_n) start |=> mem_rd ##1 done;
    endproperty
    a_read_after_start: assert property (p_read_after_start) else $error("no read/done after start");

    // Busy covers the read and the write cycle, then drops
    property p_busy_span;
        @(posedge mclk) disable iff (!reset_n) start |=> busy ##1 busy ##1 !busy;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span wrong");

    // A second read strobe would fetch the file register twice
    property p_rd_pulse;
        @(posedge mclk) disable iff (!reset_n) mem_rd |=> !mem_rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe longer than one cycle");

    // Accumulator destination: XOR lands in the accumulator, no file write
    property p_d0_no_write;
        @(posedge mclk) disable iff (!reset_n)
            (start && !bit_d) |=> ##1 !mem_wr && acc == ($past(acc) ^ $past(mem_rdata));
    endproperty
    a_d0_no_write: assert property (p_d0_no_write) else $error("d=0 wrote file");

    // Accumulator moves only when an accumulator-destination instruction completes
    property p_acc_only_done;
        @(posedge mclk) disable iff (!reset_n) $changed(acc) |-> done && !dest_q;
    endproperty
    a_acc_only_done: assert property (p_acc_only_done) else $error("acc changed without d=0 done");

    // File destination leaves the accumulator alone
    property p_d1_write;
        @(posedge mclk) disable iff (!reset_n) (start && bit_d) |=> ##1 mem_wr && $stable(acc);
    endproperty
    a_d1_write: assert property (p_d1_write) else $error("d=1 missed write");

    // Written byte is the XOR of the accumulator and the file data fetched
    property p_wdata;
        @(posedge mclk) disable iff (!reset_n)
            (start && bit_d) |=> ##1 mem_wdata == ($past(acc) ^ $past(mem_rdata));
    endproperty
    a_wdata: assert property (p_wdata) else $error("written byte wrong");

    // No file write except as the completion of a file-destination instruction
    property p_wr_with_done;
        @(posedge mclk) disable iff (!reset_n) mem_wr |-> done && dest_q;
    endproperty
    a_wr_with_done: assert property (p_wr_with_done) else $error("stray file write");

    // Access bank, lower part (f below 60h)
    property p_access;
        @(posedge mclk) disable iff (!reset_n)
            (start && !bit_a && !ext_enable && f_field < `XAF_ACC_SPLIT) |=> mem_addr == ADDR_W'($past(f_field));
    endproperty
    a_access: assert property (p_access) else $error("access bank address wrong");

    // Access bank, upper part (f at 60h and above)
    property p_access_hi;
        @(posedge mclk) disable iff (!reset_n) (start && !bit_a && !ext_enable && f_field >= `XAF_ACC_SPLIT)
            |=> mem_addr == ADDR_W'({`XAF_ACC_HI, $past(f_field)});
    endproperty
    a_access_hi: assert property (p_access_hi) else $error("upper access bank address wrong");

    // Banked access ignores the extension
    property p_banked;
        @(posedge mclk) disable iff (!reset_n)
            (start && bit_a) |=> mem_addr == ADDR_W'({$past(bank_select_pointer), $past(f_field)});
    endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong");

    // Above the offset limit the extension falls back to the access bank
    property p_indexed;
        @(posedge mclk) disable iff (!reset_n) (start && !bit_a && ext_enable && f_field > `XAF_ILO_MAX)
            |=> mem_addr == ADDR_W'({`XAF_ACC_HI, $past(f_field)});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed range wrong");

    // Offset added to the second indirect pointer
    property p_offset;
        @(posedge mclk) disable iff (!reset_n) (start && !bit_a && ext_enable && f_field <= `XAF_ILO_MAX)
            |=> mem_addr == ADDR_W'($past(indirect_pointer_two) + ADDR_W'($past(f_field)));
    endproperty
    a_offset: assert property (p_offset) else $error("offset not added");

    // Flags follow the XOR of the operands fetched, for either destination
    property p_flags;
        @(posedge mclk) disable iff (!reset_n) done |-> flag_z == (($past(acc) ^ $past(mem_rdata)) == `XAF_ZERO_BYTE)
            && flag_n == $past(acc[`XAF_SIGN_BIT] ^ mem_rdata[`XAF_SIGN_BIT]);
    endproperty
    a_flags: assert property (p_flags) else $error("flags wrong");

    // Flags hold between completions
    property p_flags_hold;
        @(posedge mclk) disable iff (!reset_n) !done |-> $stable(flag_z) && $stable(flag_n);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved without done");

    // Main scenarios: each destination, indexed mode, zero result, request dropped while busy
    c_d0: cover property (@(posedge mclk) disable iff (!reset_n) start && !bit_d);
    c_d1: cover property (@(posedge mclk) disable iff (!reset_n) start && bit_d);
    c_idx: cover property (@(posedge mclk) disable iff (!reset_n) start && indexed);
    c_zero: cover property (@(posedge mclk) disable iff (!reset_n) done && flag_z);
    c_busy_drop: cover property (@(posedge mclk) disable iff (!reset_n) instr_valid && is_xor && busy);
endmodule : xaf_exec

// ==== verif/tb_top.sv ====
// Self-checking bench for the exclusive-OR accumulator-with-file execute unit
`timescale 1ns/1ns
module tb_top;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic ext_enable = 1'b0;
    logic [3:0] bank_select_pointer = 4'h0;
    logic [11:0] indirect_pointer_two = 12'h000;
    logic [7:0] mem_rdata = 8'h00;
    logic [11:0] mem_addr;
    logic mem_rd, mem_wr, flag_n, flag_z, done, busy;
    logic [7:0] mem_wdata, acc;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    xaf_exec DUT (.mclk(mclk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
        .ext_enable(ext_enable), .bank_select_pointer(bank_select_pointer),
        .indirect_pointer_two(indirect_pointer_two), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .acc(acc), .flag_n(flag_n),
        .flag_z(flag_z), .done(done), .busy(busy));
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    initial begin
        forever #10 mclk = ~mclk;
    end
    // Hang guard: the whole run needs well under 100 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One instruction; returns in the cycle done is high. Read data is garbled after use.
    task automatic op(input logic [15:0] w, input logic ext, input logic [7:0] rd, input logic [11:0] ea);
        @(posedge mclk) #1;
        instr_word = w;
        ext_enable = ext;
        instr_valid = 1'b1;
        mem_rdata = rd;
        @(posedge mclk) #1;
        instr_valid = 1'b0;
        chk({10'h0, busy, mem_rd}, 12'h003);
        chk(mem_addr, ea);
        @(posedge mclk) #1;
        mem_rdata = ~rd;
        chk({11'h0, done}, 12'h001);
    endtask : op
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_banked_to_acc();
        bank_select_pointer = 4'h3;
        op(16'h1912, 1'b1, 8'ha5, 12'h312);
        chk({4'h0, acc}, 12'h0a5);
        chk({11'h0, mem_wr}, 12'h000);
        chk({10'h0, flag_n, flag_z}, 12'h002);
        $display("test banked_to_acc done");
    endtask : t_banked_to_acc
    task automatic t_to_file();
        op(16'h1a80, 1'b0, 8'ha5, 12'hf80);
        chk({3'h0, mem_wr, mem_wdata}, 12'h100);
        chk({4'h0, acc}, 12'h0a5);
        chk({10'h0, flag_n, flag_z}, 12'h001);
        $display("test to_file done");
    endtask : t_to_file
    task automatic t_indexed();
        indirect_pointer_two = 12'h100;
        op(16'h185f, 1'b1, 8'h0f, 12'h15f);
        chk({2'h0, flag_n, flag_z, acc}, 12'h2aa);
        op(16'h1860, 1'b1, 8'haa, 12'hf60);
        chk({2'h0, flag_n, flag_z, acc}, 12'h100);
        op(16'h1810, 1'b0, 8'h3c, 12'h010);
        chk({4'h0, acc}, 12'h03c);
        $display("test indexed done");
    endtask : t_indexed
    task automatic t_refused();
        @(posedge mclk) #1;
        instr_word = 16'h1c10;
        instr_valid = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        instr_valid = 1'b0;
        chk({10'h0, busy, mem_rd}, 12'h000);
        $display("test refused done");
    endtask : t_refused
    task automatic t_busy();
        @(posedge mclk) #1;
        instr_word = 16'h1805;
        ext_enable = 1'b0;
        mem_rdata = 8'h81;
        instr_valid = 1'b1;
        @(posedge mclk) #1;
        instr_word = 16'h1a77;
        chk({10'h0, busy, mem_rd}, 12'h003);
        chk(mem_addr, 12'h005);
        @(posedge mclk) #1;
        chk({2'h0, flag_n, flag_z, acc}, 12'h2bd);
        @(posedge mclk) #1;
        instr_valid = 1'b0;
        chk({10'h0, busy, mem_rd}, 12'h000);
        chk(mem_addr, 12'h005);
        $display("test busy done");
    endtask : t_busy
    task automatic t_reset();
        @(posedge mclk) #1;
        reset_n = 1'b0;
        #1;
        chk({acc, flag_n, flag_z, busy, done}, 12'h000);
        @(posedge mclk) #1;
        reset_n = 1'b1;
        op(16'h1b05, 1'b0, 8'h5a, 12'h305);
        chk({3'h0, mem_wr, mem_wdata}, 12'h15a);
        chk({2'h0, flag_n, flag_z, acc}, 12'h000);
        $display("test reset done");
    endtask : t_reset
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (2) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        t_banked_to_acc();
        t_to_file();
        t_indexed();
        t_busy();
        t_reset();
        t_refused();
        conclude();
    end
endmodule : tb_top
